// ### inc/jtr_regs.vh
// Constants for the four-wire test access port with reprogramming gate
`ifndef JTR_REGS_VH
`define JTR_REGS_VH
`define JTR_IR_W        4
`define JTR_IR_BYPASS   4'hf
`define JTR_IR_IDCODE   4'h1
`define JTR_IR_ENABLE   4'h9
`define JTR_IR_ERASE    4'ha
`define JTR_IR_PROGRAM  4'hb
`define JTR_IR_VERIFY   4'hc
`define JTR_IR_CAPTURE  4'h1
`define JTR_ST_RESET    16'h0001
`define JTR_ST_IDLE     16'h0002
`define JTR_ST_SEL_DR   16'h0004
`define JTR_ST_CAP_DR   16'h0008
`define JTR_ST_SH_DR    16'h0010
`define JTR_ST_EX1_DR   16'h0020
`define JTR_ST_PA_DR    16'h0040
`define JTR_ST_EX2_DR   16'h0080
`define JTR_ST_UP_DR    16'h0100
`define JTR_ST_SEL_IR   16'h0200
`define JTR_ST_CAP_IR   16'h0400
`define JTR_ST_SH_IR    16'h0800
`define JTR_ST_EX1_IR   16'h1000
`define JTR_ST_PA_IR    16'h2000
`define JTR_ST_EX2_IR   16'h4000
`define JTR_ST_UP_IR    16'h8000
`endif

// ### rtl/jtr_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module jtr_sync (
  input  wire sys_clk,
  input  wire rst,
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Change counts once stages two and three agree
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

// ### rtl/jtr_tap.v
// Test access port controller with gated reprogramming instructions
`timescale 1ns/1ps
`include "jtr_regs.vh"
module jtr_tap #(
  parameter ROW_W   = 16,
  parameter ADDR_W  = 8,
  parameter ID_CODE = 32'h00000001   // Arbitrary neutral value
) (
  input  wire              sys_clk,
  input  wire              rst,          // Power-up reset
  input  wire              tck,          // Four wires, no test reset pin
  input  wire              tms,
  input  wire              tdi,
  output reg               tdo_o,
  output reg               tdo_oe_n,
  input  wire              port_disable,  // From downloaded configuration
  input  wire [ROW_W-1:0]  row_rd_data,
  output reg  [ROW_W-1:0]  row_wr_data,
  output reg  [ADDR_W-1:0] row_addr,
  output reg               erase_req,
  output reg               program_req,
  output reg               verify_req,
  output reg               gpio_mode
);
  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Pins are only observed, so their macrocells stay free for buried logic
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  jtr_sync u_tck (.sys_clk(sys_clk), .rst(rst), .pin_in(tck), .level_q(tck_s));
  jtr_sync u_tms (.sys_clk(sys_clk), .rst(rst), .pin_in(tms), .level_q(tms_s));
  jtr_sync u_tdi (.sys_clk(sys_clk), .rst(rst), .pin_in(tdi), .level_q(tdi_s));

  reg  tck_d_q;
  wire tck_rise = tck_s & ~tck_d_q;
  wire tck_fall = ~tck_s & tck_d_q;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  reg [15:0]           st_q;
  reg [15:0]           st_d;
  reg [`JTR_IR_W-1:0]  ir_sh_q;
  reg [`JTR_IR_W-1:0]  ir_q;
  reg                  byp_q;
  reg [31:0]           id_sh_q;
  reg [ROW_W-1:0]      rp_sh_q;
  reg                  unlock_q;
  reg                  active_q;   // Port still owned by

  always @* begin
    st_d = `JTR_ST_RESET;
    case (st_q)
      `JTR_ST_RESET:  st_d = tms_s ? `JTR_ST_RESET  : `JTR_ST_IDLE;
      `JTR_ST_IDLE:   st_d = tms_s ? `JTR_ST_SEL_DR : `JTR_ST_IDLE;
      `JTR_ST_SEL_DR: st_d = tms_s ? `JTR_ST_SEL_IR : `JTR_ST_CAP_DR;
      `JTR_ST_CAP_DR: st_d = tms_s ? `JTR_ST_EX1_DR : `JTR_ST_SH_DR;
      `JTR_ST_SH_DR:  st_d = tms_s ? `JTR_ST_EX1_DR : `JTR_ST_SH_DR;
      `JTR_ST_EX1_DR: st_d = tms_s ? `JTR_ST_UP_DR  : `JTR_ST_PA_DR;
      `JTR_ST_PA_DR:  st_d = tms_s ? `JTR_ST_EX2_DR : `JTR_ST_PA_DR;
      `JTR_ST_EX2_DR: st_d = tms_s ? `JTR_ST_UP_DR  : `JTR_ST_SH_DR;
      `JTR_ST_UP_DR:  st_d = tms_s ? `JTR_ST_SEL_DR : `JTR_ST_IDLE;
      `JTR_ST_SEL_IR: st_d = tms_s ? `JTR_ST_RESET  : `JTR_ST_CAP_IR;
      `JTR_ST_CAP_IR: st_d = tms_s ? `JTR_ST_EX1_IR : `JTR_ST_SH_IR;
      `JTR_ST_SH_IR:  st_d = tms_s ? `JTR_ST_EX1_IR : `JTR_ST_SH_IR;
      `JTR_ST_EX1_IR: st_d = tms_s ? `JTR_ST_UP_IR  : `JTR_ST_PA_IR;
      `JTR_ST_PA_IR:  st_d = tms_s ? `JTR_ST_EX2_IR : `JTR_ST_PA_IR;
      `JTR_ST_EX2_IR: st_d = tms_s ? `JTR_ST_UP_IR  : `JTR_ST_SH_IR;
      `JTR_ST_UP_IR:  st_d = tms_s ? `JTR_ST_SEL_DR : `JTR_ST_IDLE;
      default:        st_d = `JTR_ST_RESET;
    endcase
  end

  // Decode; unknown codes fall to bypass, reprogramming needs unlock
  wire sel_id  = (ir_q == `JTR_IR_IDCODE);
  wire sel_rp  = unlock_q & ((ir_q == `JTR_IR_ENABLE) | (ir_q == `JTR_IR_ERASE) |
                 (ir_q == `JTR_IR_PROGRAM) | (ir_q == `JTR_IR_VERIFY));
  wire [ROW_W-1:0] rp_next = {tdi_s, rp_sh_q[ROW_W-1:1]};

  // ----------------------------------------------------------------
  // Rising edge work: state, capture and shift
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tck_d_q     <= 1'b1;  // Matches parked-high clock, no false edge after reset
      st_q        <= `JTR_ST_RESET;
      ir_sh_q     <= `JTR_IR_BYPASS;
      ir_q        <= `JTR_IR_BYPASS;
      byp_q       <= 1'b0;
      id_sh_q     <= 32'h00000000;
      rp_sh_q     <= {ROW_W{1'b0}};
      unlock_q    <= 1'b0;
      active_q    <= 1'b1;
      gpio_mode   <= 1'b0;
      row_wr_data <= {ROW_W{1'b0}};
      row_addr    <= {ADDR_W{1'b0}};
      erase_req   <= 1'b0;
      program_req <= 1'b0;
      verify_req  <= 1'b0;
    end else begin
      tck_d_q     <= tck_s;
      erase_req   <= 1'b0;
      program_req <= 1'b0;
      verify_req  <= 1'b0;
      // Once disabled the pins stay general I/O until power-up
      if (port_disable) begin
        active_q  <= 1'b0;
        gpio_mode <= 1'b1;
      end
      if (tck_rise && active_q && !port_disable) begin
        st_q <= st_d;
        case (st_q)
          `JTR_ST_RESET: begin
            ir_q     <= `JTR_IR_BYPASS;
            unlock_q <= 1'b0;
          end
          `JTR_ST_CAP_IR: ir_sh_q <= `JTR_IR_CAPTURE;
          `JTR_ST_SH_IR:  ir_sh_q <= {tdi_s, ir_sh_q[`JTR_IR_W-1:1]};
          `JTR_ST_UP_IR: begin
            ir_q <= ir_sh_q;
            if (ir_sh_q == `JTR_IR_ENABLE) begin
              unlock_q <= 1'b1;  // Stays unlocked across later codes
            end
          end
          `JTR_ST_CAP_DR: begin
            byp_q   <= 1'b0;
            id_sh_q <= ID_CODE;
            if (sel_rp && (ir_q == `JTR_IR_VERIFY)) begin
              rp_sh_q <= row_rd_data;
            end
          end
          `JTR_ST_SH_DR: begin
            byp_q   <= tdi_s;
            id_sh_q <= {tdi_s, id_sh_q[31:1]};
            if (sel_rp) begin
              rp_sh_q <= rp_next;
            end
          end
          `JTR_ST_UP_DR: begin
            if (sel_rp) begin
              case (ir_q)
                `JTR_IR_ERASE: erase_req <= 1'b1;
                `JTR_IR_PROGRAM: begin
                  program_req <= 1'b1;
                  row_wr_data <= rp_sh_q;
                end
                `JTR_IR_VERIFY: verify_req <= 1'b1;
                default: row_addr <= rp_sh_q[ADDR_W-1:0];
              endcase
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Falling edge work: data out
  // ----------------------------------------------------------------
  // Mux picks the IR chain in Shift-IR, else by instruction; single bypass stage keeps chains aligned
  wire sh_ir = (st_q == `JTR_ST_SH_IR);
  wire sh_dr = (st_q == `JTR_ST_SH_DR);
  reg  out_bit;
  always @* begin
    out_bit = byp_q;
    if (sh_ir) begin
      out_bit = ir_sh_q[0];
    end else if (sel_id) begin
      out_bit = id_sh_q[0];
    end else if (sel_rp) begin
      out_bit = rp_sh_q[0];
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tdo_o    <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (!active_q || port_disable) begin
      tdo_oe_n <= 1'b1;  // Release in the same cycle the mode flag rises
    end else if (tck_fall) begin
      tdo_o    <= out_bit;
      tdo_oe_n <= ~(sh_ir | sh_dr);
    end
  end
endmodule

// ### tb/jtr_host.sv
// Behavioural boundary-scan controller on the far side of the port
`timescale 1ns/1ps
module jtr_host (
  input  logic sys_clk,
  input  logic tdo_o,
  input  logic tdo_oe_n,
  output logic tck = 1'b1,
  output logic tms = 1'b1,
  output logic tdi = 1'b1
);
  // --------------
  // Pin sequencing
  // --------------
  // Clock parks high; data out read late in the high phase, as the device
  // answers several system clocks after the fall
  task automatic step(input logic m, input logic din, output logic o);
    tck = 1'b0;
    tms = m;
    tdi = din;
    repeat (4) @(negedge sys_clk);
    tck = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Released line rests at its pull-up level
    o = tdo_oe_n ? 1'b1 : tdo_o;
  endtask
  task automatic tlr();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
endmodule

// ### tb/jtr_tap_chk.sv
// Concurrent checks on the test port outputs
`timescale 1ns/1ps
module jtr_chk (
  input logic sys_clk,
  input logic rst,
  input logic tdo_o,
  input logic tdo_oe_n,
  input logic port_disable,
  input logic erase_req,
  input logic program_req,
  input logic verify_req,
  input logic gpio_mode
);
  // ------
  // Checks
  // ------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_hold;
    $stable(tdo_o)[*3];
  endsequence
  sequence s_gpio;
    ##[0:6] gpio_mode;
  endsequence
  wire any_req = erase_req | program_req | verify_req;
  chk_tdo_hold: assert property ($changed(tdo_o) |=> s_hold) else $error("tdo glitch");
  chk_erase_pulse: assert property (erase_req |=> !erase_req) else $error("erase long");
  chk_prog_pulse: assert property (program_req |=> !program_req) else $error("prog long");
  chk_verify_pulse: assert property (verify_req |=> !verify_req) else $error("vfy long");
  chk_one_req: assert property ($onehot0({erase_req, program_req, verify_req}))
    else $error("req clash");
  chk_gpio_float: assert property (gpio_mode |-> tdo_oe_n && !any_req)
    else $error("active");
  chk_gpio_keep: assert property (gpio_mode |=> gpio_mode) else $error("gpio drop");
  chk_dis_gpio: assert property ($rose(port_disable) |-> s_gpio) else $error("no gpio");
endmodule
bind jtr_tap jtr_chk u_chk (.sys_clk, .rst, .tdo_o, .tdo_oe_n, .port_disable, .erase_req,
  .program_req, .verify_req, .gpio_mode);

// ### tb/jtr_tap_tb.sv
// Self-checking bench for the gated test access port
`timescale 1ns/1ps
`include "jtr_regs.vh"
module jtr_tap_tb;
  localparam logic [31:0] ID = 32'h00a5_5a01; // Arbitrary value
  logic        sys_clk = 1'b0, rst = 1'b1, port_disable = 1'b0;
  logic [15:0] row_rd_data = 16'h0000, row_wr_data;
  logic [7:0]  row_addr;
  logic [31:0] q, qi, d;
  logic        tck, tms, tdi, tdo_o, tdo_oe_n, erase_req, program_req, verify_req, gpio_mode;
  logic [3:0]  codes[5] = '{4'ha, 4'hb, 4'hc, 4'h3, 4'h7};
  int          fails = 0, cmp_count = 0, cyc = 0, ne = 0, np = 0, nv = 0;
  always #10 sys_clk = ~sys_clk;
  jtr_tap #(.ID_CODE(ID)) u_dut (.sys_clk, .rst, .tck, .tms, .tdi, .tdo_o, .tdo_oe_n,
    .port_disable, .row_rd_data, .row_wr_data, .row_addr, .erase_req, .program_req,
    .verify_req, .gpio_mode);
  jtr_host u_host (.sys_clk, .tdo_o, .tdo_oe_n, .tck, .tms, .tdi);
  // ---------------
  // Model and tasks
  // ---------------
  always @(posedge sys_clk) begin
    cyc++;
    ne += erase_req;
    np += program_req;
    nv += verify_req;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-stage pass-through: capture zero first, then input delayed by one
  function automatic logic [31:0] byp_model(input logic [31:0] din, input int n);
    logic        fifo[$];
    logic [31:0] r;
    r = '0;
    fifo.push_back(1'b0);
    for (int i = 0; i < n; i++) begin
      r[i] = fifo.pop_front();
      fifo.push_back(din[i]);
    end
    return r;
  endfunction
  task automatic op(input logic [3:0] ir, input int n, input logic [31:0] din);
    u_host.scan(1'b1, 4, 32'(ir), qi);
    u_host.scan(1'b0, n, din, q);
    // Last clock rise is acted on several system clocks after the pin moves
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h811f));
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("oe_idle", 32'(tdo_oe_n), 32'h1);
    u_host.tlr();
    d = $urandom;
    op(4'hf, 16, d);
    chk("ir_cap", qi, 32'h1);
    chk("bypass", q, byp_model(d, 16));
    op(`JTR_IR_IDCODE, 32, d);
    chk("idcode", q, ID);
    foreach (codes[i]) begin
      op(codes[i], 16, d);
      chk("ungated", q, byp_model(d, 16));
    end
    chk("no_req", 32'(ne + np + nv), 32'h0);
    op(`JTR_IR_ENABLE, 16, d);
    chk("row_addr", 32'(row_addr), 32'(d[7:0]));
    op(`JTR_IR_ERASE, 16, d);
    chk("erase", 32'(ne), 32'h1);
    d = $urandom;
    op(`JTR_IR_PROGRAM, 16, d);
    chk("wr_data", 32'(row_wr_data), 32'(d[15:0]));
    chk("program", 32'(np), 32'h1);
    row_rd_data = 16'($urandom);
    op(`JTR_IR_VERIFY, 16, d);
    chk("verify", q, 32'(row_rd_data));
    chk("verify_req", 32'(nv), 32'h1);
    u_host.tlr();
    op(`JTR_IR_ERASE, 16, d);
    chk("relock", 32'(ne), 32'h1);
    port_disable = 1'b1;
    op(4'hf, 16, d);
    chk("gone", q, 32'h0000ffff);
    chk("gpio", 32'(gpio_mode), 32'h1);
    wrap_up();
  end
endmodule
